// ===== include/sba_map.svh
// Register map, field positions, reset values and timing counts of the
// system bus arbiter. Assumes inclusion by bare name from the package.
`ifndef SBA_MAP_SVH
`define SBA_MAP_SVH
// Register offsets
`define SBA_OFS_CTL 8'h70
`define SBA_OFS_STA 8'h71
`define SBA_OFS_PRI 8'h74
// Control fields
`define SBA_CTL_PARK 0
`define SBA_CTL_RST 8'h00
// Status fields
`define SBA_STA_FLAG 7
`define SBA_STA_IDX 2:0
// Priority control fields
`define SBA_PRI_A_SEL 2:0
`define SBA_PRI_A_EN 3
`define SBA_PRI_B_SEL 6:4
`define SBA_PRI_B_EN 7
`define SBA_PRI_RATIO 9:8
`define SBA_PRI_RST 10'h100
// Master numbering and timing
`define SBA_NEXT 5
`define SBA_HOST 3'h5
`define SBA_TMO_CLKS 5'd16
`endif

// ===== include/sba_pkg.sv
// Types shared by the arbiter modules.
// Assumes the map header sits on the include path.
`include "sba_map.svh"
package sba_pkg;
  // PCI grant sequencer states
  typedef enum logic [2:0] {P_PARK, P_GRANT, P_BUSY, P_GAP} sba_pst_type;
  // Memory bus hand-over states
  typedef enum logic [2:0] {C_IDLE, C_CORE, C_HOLD, C_MST, C_REL, C_WB, C_WBH} sba_cst_type;
endpackage : sba_pkg

// ===== src/sba_sync.sv
// Two-stage synchroniser for the PCI pins.
// Assumes pin levels may change at any time relative to clk.
module sba_sync
  import sba_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [6:0] din,
  output logic [6:0] dout
);
  // Both stages held together
  typedef struct packed {
    logic [6:0] s1;
    logic [6:0] s2;
  } sba_sync_type;

  sba_sync_type s;
  sba_sync_type n;

  // Next stage values; first stage feeds only the second
  always_comb
  begin
    n.s1 = din;
    n.s2 = s.s1;
  end

  // Pins idle high after reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s <= '1;
    end
    else
    begin
      s <= n;
    end
  end

  assign dout = s.s2;
endmodule : sba_sync

// ===== src/sba_cpu_arb.sv
// Memory bus hand-over between the processor core and two internal masters.
// Assumes all strobes come from logic on clk, active high.
module sba_cpu_arb
  import sba_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic core_breq,
  input wire logic core_hlda,
  input wire logic core_ads,
  input wire logic core_hitm,
  input wire logic [1:0] mst_req,
  input wire logic [1:0] mst_ads,
  output logic core_hold,
  output logic [1:0] mst_gnt
);
  // Whole state of the hand-over logic
  typedef struct packed {
    sba_cst_type st;
    logic cur;
    logic core_next;
    logic hold;
    logic [1:0] gnt;
  } sba_cpu_type;

  sba_cpu_type s;
  sba_cpu_type n;
  logic nxt_m;

  // Other master first when it asks
  assign nxt_m = mst_req[~s.cur] ? ~s.cur : s.cur;

  // Hand-over sequencer
  always_comb
  begin
    n = s;
    case (s.st)
      C_IDLE:
      begin
        if (core_hlda && core_breq && (s.core_next || mst_req == 2'b00))
        begin
          n.hold = 1'b0;
          n.core_next = 1'b0;
          n.st = C_CORE;
        end
        else if (core_hlda && mst_req != 2'b00)
        begin
          n.cur = nxt_m;
          n.gnt = nxt_m ? 2'b10 : 2'b01;
          n.core_next = 1'b1;
          n.st = C_MST;
        end
      end
      C_CORE:
      begin
        if (mst_req != 2'b00 && (core_ads || !core_breq))
        begin
          n.hold = 1'b1;
          n.st = C_HOLD;
        end
      end
      C_HOLD:
      begin
        if (core_hlda && mst_req != 2'b00)
        begin
          n.cur = nxt_m;
          n.gnt = nxt_m ? 2'b10 : 2'b01;
          n.core_next = 1'b1;
          n.st = C_MST;
        end
        else if (core_hlda)
        begin
          n.st = C_IDLE;
        end
      end
      C_MST:
      begin
        if (core_hitm)
        begin
          n.gnt = 2'b00;
          n.hold = 1'b0;
          n.st = C_WB;
        end
        else if (!mst_req[s.cur])
        begin
          n.gnt = 2'b00;
          n.st = C_IDLE;
        end
        else if (mst_ads[s.cur] && core_breq)
        begin
          n.gnt = 2'b00;
          n.st = C_REL;
        end
      end
      C_REL:
      begin
        if (!mst_req[s.cur])
        begin
          n.hold = !core_breq;
          n.core_next = 1'b0;
          n.st = core_breq ? C_CORE : C_IDLE;
        end
      end
      C_WB:
      begin
        if (core_ads)
        begin
          n.hold = 1'b1;
          n.st = C_WBH;
        end
      end
      C_WBH:
      begin
        if (core_hlda && !core_hitm)
        begin
          n.gnt = s.cur ? 2'b10 : 2'b01;
          n.st = C_MST;
        end
      end
      default:
      begin
        n.st = C_IDLE;
      end
    endcase
  end

  // Core held off until it acknowledges after reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s.st <= C_IDLE;
      s.cur <= 1'b0;
      s.core_next <= 1'b1;
      s.hold <= 1'b1;
      s.gnt <= 2'b00;
    end
    else
    begin
      s <= n;
    end
  end

  assign core_hold = s.hold;
  assign mst_gnt = s.gnt;

  chk_hlda_grant_master: assert property (@(posedge clk) disable iff (!rst_n)
    (s.st == C_HOLD && core_hlda && mst_req != 2'b00) |=> $onehot(mst_gnt))
    else $error("no grant after hold acknowledge");
  chk_ads_rehold_core: assert property (@(posedge clk) disable iff (!rst_n)
    (s.st == C_CORE && core_ads && mst_req != 2'b00) |=> core_hold)
    else $error("hold not reasserted on core strobe");
  chk_hitm_wb_release: assert property (@(posedge clk) disable iff (!rst_n)
    (s.st == C_MST && core_hitm) |=> (!core_hold && mst_gnt == 2'b00))
    else $error("hold not released for write-back");
endmodule : sba_cpu_arb

// ===== src/sba_arbiter.sv
// Top of the system bus arbiter: PCI grant logic, registers, and the
// memory bus hand-over. Assumes PCI pins are asynchronous to clk and the
// host bridge and internal masters run on clk.
//
// Design decision made here: strobed register access.
module sba_arbiter
  import sba_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [15:0] reg_rdata,
  input wire logic [4:0] pci_req_n,
  input wire logic pci_frame_n,
  input wire logic pci_irdy_n,
  output logic [4:0] pci_gnt_n,
  input wire logic host_req,
  output logic host_gnt,
  input wire logic core_breq,
  input wire logic core_hlda,
  input wire logic core_ads,
  input wire logic core_hitm,
  input wire logic [1:0] mst_req,
  input wire logic [1:0] mst_ads,
  output logic core_hold,
  output logic [1:0] mst_gnt
);
  // Whole state of the PCI side
  typedef struct packed {
    sba_pst_type st;
    logic [2:0] gsel;
    logic gon;
    logic [5:0] gv;
    logic [1:0] gph;
    logic [1:0] phase;
    logic [2:0] lp;
    logic [1:0] ecnt;
    logic [4:0] tmo;
    logic frame_d;
    logic [7:0] ctl;
    logic sflag;
    logic [2:0] sidx;
    logic [9:0] pri;
    logic [15:0] rdata;
  } sba_pci_type;

  sba_pci_type s;
  sba_pci_type n;
  // Synchronised pins: irdy, frame, requests
  logic [6:0] pin_q;
  // Requests, host bridge in bit 5
  logic [5:0] rq;
  logic frame_s;
  logic bus_idle;
  logic start;
  logic host_due;
  logic [1:0] ratio;
  // Arbitration result: valid, phase, index
  logic [5:0] pk;
  logic pk_v;
  logic [1:0] pk_ph;
  logic [2:0] pk_idx;
  // Rotation advance request
  logic adv;
  logic [1:0] adv_ph;
  logic [2:0] adv_idx;
  logic tmo_hit;
  logic sta_clr;

  // One-hot grant vector of a master index
  function automatic logic [5:0] sba_onehot(input logic [2:0] idx);
    logic [5:0] v;
    v = 6'h00;
    v[idx] = 1'b1;
    return v;
  endfunction : sba_onehot

  // Next master: host when due, then slots from the current phase
  function automatic logic [5:0] sba_pick(
    input logic [5:0] r,
    input logic [1:0] ph,
    input logic [2:0] lpp,
    input logic [9:0] pc,
    input logic due
  );
    logic [5:0] res;
    logic found;
    logic [1:0] p;
    logic [2:0] m;
    res = 6'h00;
    found = 1'b0;
    if (r[5] && (due || r[4:0] == 5'h00))
    begin
      res = {1'b1, 2'h3, `SBA_HOST};
      found = 1'b1;
    end
    // two high slots then one low
    for (int k = 0; k < 3; k++)
    begin
      p = 2'((int'(ph) + k) % 3);
      // high slots may name same master
      if (!found && p == 2'h0 && pc[`SBA_PRI_A_EN] && r[pc[`SBA_PRI_A_SEL]])
      begin
        res = {1'b1, p, pc[`SBA_PRI_A_SEL]};
        found = 1'b1;
      end
      if (!found && p == 2'h1 && pc[`SBA_PRI_B_EN] && r[pc[`SBA_PRI_B_SEL]])
      begin
        res = {1'b1, p, pc[`SBA_PRI_B_SEL]};
        found = 1'b1;
      end
      if (!found && p == 2'h2)
      begin
        for (int j = 0; j < `SBA_NEXT; j++)
        begin
          m = 3'((int'(lpp) + j) % `SBA_NEXT);
          if (!found && r[m] && !(pc[`SBA_PRI_A_EN] && pc[`SBA_PRI_A_SEL] == m)
              && !(pc[`SBA_PRI_B_EN] && pc[`SBA_PRI_B_SEL] == m))
          begin
            res = {1'b1, p, m};
            found = 1'b1;
          end
        end
      end
    end
    return res;
  endfunction : sba_pick

  // Pin synchroniser
  sba_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din({pci_irdy_n, pci_frame_n, pci_req_n}),
    .dout(pin_q)
  );

  // Memory bus hand-over
  sba_cpu_arb u_cpu (
    .clk(clk),
    .rst_n(rst_n),
    .core_breq(core_breq),
    .core_hlda(core_hlda),
    .core_ads(core_ads),
    .core_hitm(core_hitm),
    .mst_req(mst_req),
    .mst_ads(mst_ads),
    .core_hold(core_hold),
    .mst_gnt(mst_gnt)
  );

  // host bridge plus five external requests
  assign rq = {host_req, ~pin_q[4:0]};
  assign frame_s = pin_q[5];
  assign bus_idle = pin_q[5] && pin_q[6];
  // Frame falling edge marks a transaction start
  assign start = s.frame_d && !frame_s;
  // Ratio zero behaves as one
  assign ratio = (s.pri[`SBA_PRI_RATIO] == 2'h0) ? 2'h1 : s.pri[`SBA_PRI_RATIO];
  assign host_due = s.ecnt >= ratio;
  assign pk = sba_pick(rq, s.phase, s.lp, s.pri, host_due);
  assign pk_v = pk[5];
  assign pk_ph = pk[4:3];
  assign pk_idx = pk[2:0];
  // Granted requester unused for the full idle window
  assign tmo_hit = s.st == P_GRANT && bus_idle && !start && rq[s.gsel]
                   && s.tmo == `SBA_TMO_CLKS - 5'd1;
  assign sta_clr = reg_we && reg_addr == `SBA_OFS_STA && reg_wdata[`SBA_STA_FLAG];

  // Registers, grant sequencer and rotation update
  always_comb
  begin
    n = s;
    adv = 1'b0;
    adv_ph = s.gph;
    adv_idx = s.gsel;
    n.frame_d = frame_s;
    // Register writes
    if (reg_we && reg_addr == `SBA_OFS_CTL)
    begin
      n.ctl = reg_wdata[7:0];
    end
    if (reg_we && reg_addr == `SBA_OFS_PRI)
    begin
      n.pri = reg_wdata[9:0];
    end
    if (sta_clr)
    begin
      n.sflag = 1'b0;
    end
    // Read data only in the cycle after the strobe
    n.rdata = 16'h0000;
    if (reg_re)
    begin
      case (reg_addr)
        `SBA_OFS_CTL: n.rdata = {8'h00, s.ctl};
        `SBA_OFS_STA: n.rdata = {8'h00, s.sflag, 4'h0, s.sidx};
        `SBA_OFS_PRI: n.rdata = {6'h00, s.pri};
        default: n.rdata = 16'h0000;
      endcase
    end
    // Idle clocks under an unused grant
    n.tmo = (s.st == P_GRANT && bus_idle) ? s.tmo + 5'd1 : 5'd0;
    case (s.st)
      P_PARK:
      begin
        if (start)
        begin
          adv = 1'b1;
          adv_ph = 2'h3;
          n.st = P_BUSY;
        end
        else if (pk_v && pk_idx == s.gsel)
        begin
          n.gph = pk_ph;
          n.st = P_GRANT;
        end
        else if (pk_v)
        begin
          n.gon = 1'b0;
          n.st = P_GAP;
        end
      end
      P_GRANT:
      begin
        if (start)
        begin
          adv = 1'b1;
          n.st = P_BUSY;
        end
        else if (tmo_hit)
        begin
          adv = 1'b1;
          n.gon = 1'b0;
          n.st = P_GAP;
          n.sflag = 1'b1;
          n.sidx = s.gsel;
        end
        else if (!rq[s.gsel])
        begin
          // core select parks via a gap
          n.gon = !(s.ctl[`SBA_CTL_PARK] && s.gsel != `SBA_HOST);
          n.st = n.gon ? P_PARK : P_GAP;
        end
      end
      P_BUSY:
      begin
        if (!bus_idle && pk_v && pk_idx != s.gsel)
        begin
          // Bus driven: switch grants in one clock
          n.gsel = pk_idx;
          n.gph = pk_ph;
          n.st = P_GRANT;
        end
        else if (bus_idle && pk_v && pk_idx == s.gsel)
        begin
          n.gph = pk_ph;
          n.st = P_GRANT;
        end
        else if (bus_idle && pk_v)
        begin
          n.gon = 1'b0;
          n.st = P_GAP;
        end
        else if (bus_idle && s.ctl[`SBA_CTL_PARK] && s.gsel != `SBA_HOST)
        begin
          // park on core after a gap
          n.gon = 1'b0;
          n.st = P_GAP;
        end
        else if (bus_idle)
        begin
          n.st = P_PARK;
        end
      end
      P_GAP:
      begin
        n.gon = 1'b1;
        if (pk_v)
        begin
          n.gsel = pk_idx;
          n.gph = pk_ph;
          n.st = P_GRANT;
        end
        else
        begin
          // park so the bus stays driven
          n.gsel = s.ctl[`SBA_CTL_PARK] ? `SBA_HOST : s.gsel;
          n.st = P_PARK;
        end
      end
      default:
      begin
        n.st = P_GAP;
      end
    endcase
    if (adv)
    begin
      n.ecnt = (adv_idx == `SBA_HOST) ? 2'h0 : ((s.ecnt == 2'h3) ? 2'h3 : s.ecnt + 2'h1);
      if (adv_ph != 2'h3)
      begin
        n.phase = (adv_ph == 2'h2) ? 2'h0 : adv_ph + 2'h1;
      end
      // low queue moves one per pass
      if (adv_ph == 2'h2)
      begin
        n.lp = (adv_idx == 3'h4) ? 3'h0 : adv_idx + 3'h1;
      end
    end
    n.gv = n.gon ? sba_onehot(n.gsel) : 6'h00;
  end

  // Bus parked on the host bridge after reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.st <= P_PARK;
      s.gsel <= `SBA_HOST;
      s.gon <= 1'b1;
      s.gv <= 6'h20;
      s.gph <= 2'h3;
      s.frame_d <= 1'b1;
      s.ctl <= `SBA_CTL_RST;
      s.pri <= `SBA_PRI_RST;
    end
    else
    begin
      s <= n;
    end
  end

  assign pci_gnt_n = ~s.gv[4:0];
  assign host_gnt = s.gv[5];
  assign reg_rdata = s.rdata;

  chk_park_one_grant: assert property (@(posedge clk) disable iff (!rst_n)
    $onehot0(s.gv) && (s.st != P_PARK || $onehot(s.gv)))
    else $error("park grant not exactly one");
  chk_idle_gap_grant: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(bus_idle) && $past(s.gv) != 6'h00 && s.gv != 6'h00) |-> s.gv == $past(s.gv))
    else $error("grant moved on idle bus without gap");
  chk_timeout_status: assert property (@(posedge clk) disable iff (!rst_n)
    tmo_hit |=> (s.gv == 6'h00 && s.sflag && s.sidx == $past(s.gsel)))
    else $error("broken master not withdrawn and recorded");
  chk_lone_grant_kept: assert property (@(posedge clk) disable iff (!rst_n)
    (s.st == P_BUSY && !pk_v && !bus_idle) |=> s.gv == $past(s.gv))
    else $error("lone grant dropped mid transaction");
  chk_start_rearb_busy: assert property (@(posedge clk) disable iff (!rst_n)
    (start && (s.st == P_GRANT || s.st == P_PARK)) |=> s.st == P_BUSY)
    else $error("no rearbitration at transaction start");
  chk_flag_sticky_w1c: assert property (@(posedge clk) disable iff (!rst_n)
    (s.sflag && !sta_clr) |=> s.sflag)
    else $error("broken flag lost without clear");
  chk_park_core_gap: assert property (@(posedge clk) disable iff (!rst_n)
    (s.st == P_BUSY && bus_idle && !pk_v && s.ctl[`SBA_CTL_PARK] && s.gsel != `SBA_HOST)
    ##1 !pk_v |-> s.gv == 6'h00 ##1 s.gv == 6'h20)
    else $error("bus not parked on core");
endmodule : sba_arbiter

// ===== verif/sba_pci_model.sv
// Behavioural PCI masters: external masters 0..4 and the host bridge as 5.
// Assumes grants come registered from the arbiter on clk; idle lines pulled up.
module sba_pci_model
  import sba_pkg::*;
(
  input wire logic clk,
  input wire logic [5:0] want,
  input wire logic [5:0] broken,
  input wire logic [4:0] pci_gnt_n,
  input wire logic host_gnt,
  output logic [4:0] pci_req_n,
  output logic host_req,
  output logic pci_frame_n,
  output logic pci_irdy_n,
  output logic start_stb,
  output logic [2:0] start_idx
);
  timeunit 1ns;
  timeprecision 1ps;
  // Cycles left in the running transaction
  logic [2:0] len_r = 3'h0;
  // Grants in master order, host bridge on top
  wire [5:0] gnt = {host_gnt, ~pci_gnt_n};
  assign pci_req_n = ~want[4:0];
  assign host_req = want[5];
  // Released bus lines rest high
  initial
  begin
    pci_frame_n = 1'b1;
    pci_irdy_n = 1'b1;
    start_stb = 1'b0;
    start_idx = 3'h0;
  end
  // start on idle bus only when granted; broken ones never start
  always @(posedge clk)
  begin
    start_stb <= 1'b0;
    if (len_r != 3'h0)
    begin
      len_r <= len_r - 3'h1;
      // Frame ends before the last data phase
      if (len_r == 3'h2)
        pci_frame_n <= 1'b1;
      if (len_r == 3'h1)
        pci_irdy_n <= 1'b1;
    end
    else if (pci_frame_n && pci_irdy_n)
      for (int i = 0; i < 6; i++)
        if (gnt[i] && want[i] && !broken[i])
        begin
          pci_frame_n <= 1'b0;
          pci_irdy_n <= 1'b0;
          len_r <= 3'h4;
          start_stb <= 1'b1;
          start_idx <= 3'(i);
        end
  end
endmodule : sba_pci_model

// ===== verif/tb.sv
// Self-checking bench: registers, PCI grant order, parking, timeout, memory bus.
// Assumes the map header on the include path and the PCI master model.
`include "sba_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [15:0] reg_rdata;
  logic [4:0] pci_req_n;
  logic pci_frame_n;
  logic pci_irdy_n;
  logic [4:0] pci_gnt_n;
  logic host_req;
  logic host_gnt;
  logic core_breq = 1'b0;
  logic core_hlda = 1'b1;
  logic core_ads = 1'b0;
  logic core_hitm = 1'b0;
  logic [1:0] mst_req = 2'h0;
  logic [1:0] mst_ads = 2'h0;
  logic core_hold;
  logic [1:0] mst_gnt;
  logic [5:0] want = 6'h00;
  logic [5:0] broken = 6'h00;
  logic start_stb;
  logic [2:0] start_idx;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int zrun = 0;
  int idl = 0;
  logic [5:0] g_q = 6'h00;
  logic [15:0] d;
  // Memory bus steps {breq, hlda, ads, hitm, req, ads} and {hold, gnt}
  logic [7:0] mv [11] = '{8'hc0, 8'ha4, 8'hc4, 8'hc5, 8'hc0, 8'h28, 8'h48, 8'h58, 8'h38,
    8'h58, 8'h48};
  logic [2:0] me [11] = '{3'h0, 3'h4, 3'h5, 3'h4, 3'h0, 3'h4, 3'h6, 3'h0, 3'h4, 3'h4, 3'h6};
  // All PCI grants, host bridge on top
  wire [5:0] gnt_v = {host_gnt, ~pci_gnt_n};
  // Grant fault: two grants, long gap, or direct switch on an idle bus
  wire gerr = $countones(gnt_v) > 1 || (gnt_v == 6'h00 && zrun > 0) ||
    (idl > 4 && g_q != 6'h00 && gnt_v != 6'h00 && gnt_v != g_q);
  sba_arbiter dut
  (
    .clk, .rst_n, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata, .pci_req_n,
    .pci_frame_n, .pci_irdy_n, .pci_gnt_n, .host_req, .host_gnt, .core_breq, .core_hlda,
    .core_ads, .core_hitm, .mst_req, .mst_ads, .core_hold, .mst_gnt
  );
  sba_pci_model pm
  (
    .clk, .want, .broken, .pci_gnt_n, .host_gnt, .pci_req_n, .host_req, .pci_frame_n,
    .pci_irdy_n, .start_stb, .start_idx
  );
  // Free-running clock
  initial
  begin
    forever #5 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // Verdict and end of run
  task automatic finish_test();
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  // Watchdog and grant monitor, sampled before the edge updates land
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    idl <= (pci_frame_n && pci_irdy_n) ? idl + 1 : 0;
    g_q <= gnt_v;
    zrun <= (rst_n && gnt_v == 6'h00) ? zrun + 1 : 0;
    // one grant, single gap cycle, no direct switch on idle bus
    if (rst_n)
      chk("pci_grants", 16'(gerr), 16'h0000);
    if (cyc == 30000)
    begin
      n_mismatch++;
      finish_test();
    end
  end
  // Reset for six cycles
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    want <= 6'h00;
    broken <= 6'h00;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
  endtask : do_reset
  // Register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : wr
  // Register read, data taken in the following cycle
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  // Bounded wait for a transaction start
  task automatic wait_start(output logic [2:0] idx);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (start_stb !== 1'b1 && n < 300);
    if (n >= 300)
      chk("start_seen", 16'h0000, 16'h0001);
    idx = start_idx;
  endtask : wait_start
  // Next low-slot master when master 1 holds both high slots
  function automatic logic [2:0] nl(input logic [2:0] m);
    return (m == 3'h4) ? 3'h0 : ((m == 3'h0) ? 3'h2 : m + 3'h1);
  endfunction : nl
  // Reset values, access kinds, unmapped address, read data lifetime
  task automatic t_regs();
    #1;
    chk("rst_out", 16'({core_hold, mst_gnt, host_gnt, pci_gnt_n}), 16'h013f);
    rd(`SBA_OFS_CTL);
    chk("ctl_rst", d, 16'(`SBA_CTL_RST));
    rd(`SBA_OFS_PRI);
    chk("pri_rst", d, 16'(`SBA_PRI_RST));
    rd(`SBA_OFS_STA);
    chk("sta_rst", d & 16'h0080, 16'h0000);
    wr(`SBA_OFS_CTL, 16'h0001);
    wr(8'h72, 16'hffff);
    wr(`SBA_OFS_PRI, 16'hffff);
    rd(`SBA_OFS_CTL);
    chk("ctl_rw", d, 16'h0001);
    @(posedge clk);
    #1;
    chk("rdata_idle", reg_rdata, 16'h0000);
    rd(8'h72);
    chk("unmapped", d, 16'h0000);
    rd(`SBA_OFS_PRI);
    chk("pri_rw", d, 16'h03ff);
    do_reset();
  endtask : t_regs
  // One transaction by master 0, then the idle bus parks
  task automatic t_park(input logic p, input logic [5:0] exp);
    logic [2:0] idx;
    do_reset();
    // park select set only right after reset
    wr(`SBA_OFS_CTL, 16'(p));
    @(posedge clk);
    want <= 6'h01;
    wait_start(idx);
    want <= 6'h00;
    repeat (4) @(posedge clk);
    chk("lone_gnt", 16'(gnt_v), 16'h0001);
    repeat (30) @(posedge clk);
    chk("park", 16'(gnt_v), 16'(exp));
  endtask : t_park
  // All masters busy: host every r externals, high pair then one low
  task automatic t_rot(input int r);
    logic [2:0] s [$];
    logic [2:0] e [$];
    logic [2:0] idx;
    int h;
    int k;
    do_reset();
    wr(`SBA_OFS_PRI, 16'h0099 | 16'(r << 8));
    @(posedge clk);
    want <= 6'h3f;
    repeat (40)
    begin
      wait_start(idx);
      s.push_back(idx);
    end
    want <= 6'h00;
    h = 3;
    while (s[h] != `SBA_HOST && h < 20)
      h++;
    for (int j = h + 1; j < 40; j++)
    begin
      chk("host_turn", 16'(s[j] == `SBA_HOST), 16'(((j - h) % (r + 1)) == 0));
      if (s[j] != `SBA_HOST)
        e.push_back(s[j]);
    end
    k = 0;
    while (e[k] == 3'h1 && k < 3)
      k++;
    for (int m = k; m + 3 < e.size(); m += 3)
    begin
      chk("high_pair", 16'({e[m + 1], e[m + 2]}), 16'h0009);
      chk("low_next", 16'(e[m + 3]), 16'(nl(e[m])));
    end
  endtask : t_rot
  // Master 2 granted but never starts
  task automatic t_broken();
    int n;
    do_reset();
    wr(`SBA_OFS_CTL, 16'h0001);
    @(posedge clk);
    broken <= 6'h04;
    want <= 6'h04;
    n = 0;
    while (pci_gnt_n[2] !== 1'b0 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (pci_gnt_n[2] === 1'b0 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    want <= 6'h00;
    chk("tmo_len", 16'(n >= 16 && n <= 19), 16'h0001);
    rd(`SBA_OFS_STA);
    chk("sta_set", d & 16'h0087, 16'h0082);
    repeat (20) @(posedge clk);
    chk("park_core", 16'(gnt_v), 16'h0020);
    rd(`SBA_OFS_STA);
    chk("sta_held", d & 16'h0087, 16'h0082);
    wr(`SBA_OFS_STA, 16'h0080);
    rd(`SBA_OFS_STA);
    chk("sta_clr", d & 16'h0080, 16'h0000);
  endtask : t_broken
  // One memory bus step, ads pulses one cycle, outputs looked at after answer
  task automatic mb(input logic [7:0] v);
    @(posedge clk);
    {core_breq, core_hlda, core_ads, core_hitm, mst_req, mst_ads} <= v;
    @(posedge clk);
    core_ads <= 1'b0;
    mst_ads <= 2'h0;
    #1;
  endtask : mb
  // Core and master hand-over, then snoop write-back
  task automatic t_mem();
    do_reset();
    // far side steps follow the handshake
    for (int i = 0; i < 11; i++)
    begin
      mb(mv[i]);
      chk("mem_bus", 16'({core_hold, mst_gnt}), 16'(me[i]));
    end
    mb(8'h40);
  endtask : t_mem
  // Main sequence
  initial
  begin
    do_reset();
    t_regs();
    t_park(1'b0, 6'h01);
    t_park(1'b1, 6'h20);
    for (int r = 1; r <= 3; r++)
      t_rot(r);
    t_broken();
    t_mem();
    finish_test();
  end
endmodule : tb
